// ---- bench/trc_pins.sv ----
// Pin-side model: trigger source and pulled-up timer pin
`timescale 1ns/1ps
`default_nettype none
module trc_pins (
    input wire logic clock,
    input wire logic ext_pulse,
    input wire logic tmr_pulse,
    input wire logic ext_low,
    input wire logic pin_oe,
    input wire logic pin_out,
    output logic ext_trigger_pin,
    output logic timer_pin_in
);
    logic [2:0] ext_cnt = 3'h0;
    logic [2:0] tmr_cnt = 3'h0;
    // Each pulse holds the pin low four clocks, long enough for the synchroniser
    always @(posedge clock) begin
        ext_cnt <= ext_pulse ? 3'h4 : ((ext_cnt != 3'h0) ? ext_cnt - 3'h1 : ext_cnt);
        tmr_cnt <= tmr_pulse ? 3'h4 : ((tmr_cnt != 3'h0) ? tmr_cnt - 3'h1 : tmr_cnt);
    end
    // Released pins rest high on their pull-ups; the block wins while it drives
    assign ext_trigger_pin = !(ext_low || ext_cnt != 3'h0);
    assign timer_pin_in = pin_oe ? pin_out : (tmr_cnt == 3'h0);
endmodule
`default_nettype wire

// ---- bench/trc_timer_tb.sv ----
// Self-checking bench for the reload/capture timer
`timescale 1ns/1ps
`default_nettype none
module trc_timer_tb;
    typedef struct {
        logic [7:0] c;
        logic [15:0] st, rl;
        int tp, ep;
        logic el;
        logic [15:0] ec, er;
        logic [2:0] ef;
    } trc_row_t;
    logic clock, nrst, count_write, reload_write, overflow_clear, ext_clear;
    logic ext_pulse, tmr_pulse, ext_low, ext_trigger_pin, timer_pin_in;
    logic timer_pin_out, timer_pin_oe, overflow_flag, ext_flag, timer_irq;
    logic [15:0] count_wdata, reload_wdata, v;
    logic [7:0] count_high, count_low, reload_capture_high, reload_capture_low;
    trc_pkg::trc_ctrl_t ctrl;
    trc_row_t rows [9];
    int fails = 0;
    int total_checks = 0;
    trc_timer dut (.clock(clock), .nrst(nrst), .ctrl(ctrl), .count_write(count_write),
        .count_wdata(count_wdata), .reload_write(reload_write), .reload_wdata(reload_wdata),
        .overflow_clear(overflow_clear), .ext_clear(ext_clear),
        .ext_trigger_pin(ext_trigger_pin), .timer_pin_in(timer_pin_in),
        .timer_pin_out(timer_pin_out), .timer_pin_oe(timer_pin_oe),
        .count_high(count_high), .count_low(count_low),
        .reload_capture_high(reload_capture_high), .reload_capture_low(reload_capture_low),
        .overflow_flag(overflow_flag), .ext_flag(ext_flag), .timer_irq(timer_irq));
    trc_pins pins (.clock(clock), .ext_pulse(ext_pulse), .tmr_pulse(tmr_pulse),
        .ext_low(ext_low), .pin_oe(timer_pin_oe), .pin_out(timer_pin_out),
        .ext_trigger_pin(ext_trigger_pin), .timer_pin_in(timer_pin_in));
    task print_verdict;
        begin
            $display("checks %0d fails %0d", total_checks, fails);
            if (fails == 0 && total_checks > 0) begin
                $display("ALL TESTS PASSED");
            end else begin
                $display("TESTS FAILED");
            end
            $finish;
        end
    endtask
    task chk(input logic [15:0] g, input logic [15:0] e);
        begin
            total_checks++;
            if (g !== e) begin
                fails++;
                $display("mismatch at %0t: got %h want %h", $time, g, e);
            end
        end
    endtask
    // One pin fall, then enough quiet time for it to be accepted
    task pulse(input logic e);
        begin
            if (e) ext_pulse <= 1'b1;
            else tmr_pulse <= 1'b1;
            @(negedge clock);
            {ext_pulse, tmr_pulse} <= 2'h0;
            repeat (9) @(negedge clock);
        end
    endtask
    task run_row(input trc_row_t r);
        begin
            ctrl <= '0;
            ext_low <= r.el;
            // preload the pair, clear both flags
            {overflow_clear, ext_clear, count_write, reload_write} <= 4'hf;
            count_wdata <= r.st;
            reload_wdata <= r.rl;
            @(negedge clock);
            {overflow_clear, ext_clear, count_write, reload_write} <= 4'h0;
            // Pin level settles before the mode is armed
            repeat (6) @(negedge clock);
            ctrl <= r.c;
            repeat (3) @(negedge clock);
            repeat (r.tp) pulse(1'h0);
            repeat (r.ep) pulse(1'h1);
            chk({count_high, count_low}, r.ec);
            chk({reload_capture_high, reload_capture_low}, r.er);
            chk({13'h0, overflow_flag, ext_flag, timer_irq}, {13'h0, r.ef});
        end
    endtask
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // Watchdog sized well past the few hundred cycles the run needs
    initial begin
        #200000;
        fails++;
        print_verdict;
    end
    initial begin
        nrst = 1'b0;
        ctrl = '0;
        {count_write, reload_write, overflow_clear, ext_clear} = 4'h0;
        {ext_pulse, tmr_pulse, ext_low} = 3'h0;
        count_wdata = 16'h0000;
        reload_wdata = 16'h0000;
        // Counter-mode rows: ctrl, start, pair, timer falls, trigger falls, trigger low, count, pair, flags
        rows[0] = '{8'hc1, 16'hfffe, 16'h1234, 3, 0, 1'b0, 16'h1235, 16'h1234, 3'h5};
        rows[1] = '{8'he0, 16'hffff, 16'h7777, 2, 0, 1'b0, 16'h0001, 16'h7777, 3'h4};
        rows[2] = '{8'hc8, 16'hffff, 16'h0100, 1, 0, 1'b0, 16'h0100, 16'h0100, 3'h6};
        rows[3] = '{8'hc8, 16'h0102, 16'h0100, 3, 0, 1'b1, 16'hffff, 16'h0100, 3'h6};
        rows[4] = '{8'hc0, 16'h0010, 16'h0000, 2, 0, 1'b1, 16'h0012, 16'h0000, 3'h0};
        rows[5] = '{8'h40, 16'h0020, 16'h0000, 2, 0, 1'b0, 16'h0020, 16'h0000, 3'h0};
        rows[6] = '{8'hd1, 16'h5555, 16'h1234, 0, 1, 1'b0, 16'h1234, 16'h1234, 3'h3};
        rows[7] = '{8'hf1, 16'h4321, 16'h0000, 0, 1, 1'b0, 16'h4321, 16'h4321, 3'h3};
        rows[8] = '{8'he1, 16'h4321, 16'h0000, 0, 1, 1'b0, 16'h4321, 16'h0000, 3'h0};
        repeat (3) @(negedge clock);
        chk({count_high, count_low}, 16'h0000);
        chk({reload_capture_high, reload_capture_low}, 16'h0000);
        chk({13'h0, overflow_flag, ext_flag, timer_pin_oe}, 16'h0);
        repeat (2) @(negedge clock);
        nrst <= 1'b1;
        repeat (4) @(negedge clock);
        chk({reload_capture_high, reload_capture_low}, 16'h0);
        foreach (rows[i]) run_row(rows[i]);
        // Timer tick: two ticks per 24 clocks slow, one per clock fast
        ctrl <= 8'h80;
        count_write <= 1'b1;
        count_wdata <= 16'h0000;
        @(negedge clock);
        count_write <= 1'b0;
        repeat (30) @(negedge clock);
        v = {count_high, count_low};
        repeat (24) @(negedge clock);
        chk({count_high, count_low} - v, 16'h0002);
        ctrl <= 8'h82;
        repeat (3) @(negedge clock);
        v = {count_high, count_low};
        repeat (10) @(negedge clock);
        chk({count_high, count_low} - v, 16'h000a);
        // Up/down: once the overflow flag is cleared, the seventeenth bit must stay silent
        {count_write, reload_write, overflow_clear, ext_clear} <= 4'hf;
        count_wdata <= 16'hffff;
        reload_wdata <= 16'h0000;
        ctrl <= 8'h8b;
        @(negedge clock);
        {count_write, reload_write, overflow_clear, ext_clear} <= 4'h0;
        repeat (4) @(negedge clock);
        overflow_clear <= 1'h1;
        @(negedge clock);
        overflow_clear <= 1'h0;
        chk({13'h0, overflow_flag, ext_flag, timer_irq}, 16'h0002);
        // Clock output: overflow every two ticks flips the pin, never interrupts
        {count_write, reload_write, overflow_clear, ext_clear} <= 4'hf;
        count_wdata <= 16'hfffe;
        reload_wdata <= 16'hfffe;
        // Trigger held low: a down count would match the pair and never toggle the pin
        ext_low <= 1'h1;
        // timer-clocked reload mode, output enable and run together
        ctrl <= 8'h8f;
        @(negedge clock);
        {count_write, reload_write, overflow_clear, ext_clear} <= 4'h0;
        repeat (6) @(negedge clock);
        chk({15'h0, timer_pin_oe}, 16'h0001);
        v = {15'h0, timer_pin_out};
        repeat (2) @(negedge clock);
        chk({15'h0, timer_pin_out}, {15'h0, ~v[0]});
        chk({15'h0, timer_irq}, 16'h0);
        // Reset in mid-run clears count, pair, flags and the registered control bits
        nrst <= 1'h0;
        repeat (2) @(negedge clock);
        chk({count_high, count_low}, 16'h0000);
        chk({reload_capture_high, reload_capture_low}, 16'h0000);
        chk({13'h0, overflow_flag, ext_flag, timer_pin_oe}, 16'h0000);
        ctrl <= '0;
        nrst <= 1'h1;
        repeat (4) @(negedge clock);
        chk({count_high, count_low}, 16'h0000);
        print_verdict;
    end
endmodule
`default_nettype wire

// ---- verilog/trc_pkg.sv ----
// Shared constants and types for the reload/capture timer
package trc_pkg;
    localparam int COUNT_W = 16;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] RELOAD_RESET = 16'h0000;
    localparam logic [15:0] COUNT_TOP = 16'hffff;
    // Internal tick is every twelfth system clock when the fast select is clear
    localparam logic [3:0] PRESCALE_LAST = 4'hb;
    localparam logic [3:0] PRESCALE_RESET = 4'h0;
    // Pin synchronisers start high so reset release never looks like a falling edge on a pin resting high
    localparam logic [2:0] SYNC_RESET = 3'h7;
    localparam logic LEVEL_RESET = 1'h1;
    localparam logic FLAG_RESET = 1'h0;
    localparam logic CLK_OUT_RESET = 1'h0;
    // Pin indices inside the synchroniser array
    localparam int PIN_EXT = 0;
    localparam int PIN_TMR = 1;

    // Control bits, held as one bundle
    typedef struct packed {
        logic run_enable;
        logic counter_select;
        logic capture_reload_select;
        logic ext_enable;
        logic down_count_enable;
        logic clock_out_enable;
        logic fast_clock_select;
        logic timer_int_enable;
    } trc_ctrl_t;

    localparam trc_ctrl_t CTRL_RESET = '0;
endpackage

// ---- verilog/trc_timer.sv ----
// 16-bit timer/counter with auto-reload, capture, up/down count and clock output
`timescale 1ns/1ps
`default_nettype none
module trc_timer (
    input wire logic clock,
    input wire logic nrst,
    input wire trc_pkg::trc_ctrl_t ctrl,
    input wire logic count_write,
    input wire logic [15:0] count_wdata,
    input wire logic reload_write,
    input wire logic [15:0] reload_wdata,
    input wire logic overflow_clear,
    input wire logic ext_clear,
    input wire logic ext_trigger_pin,
    input wire logic timer_pin_in,
    output logic timer_pin_out,
    output logic timer_pin_oe,
    output logic [7:0] count_high,
    output logic [7:0] count_low,
    output logic [7:0] reload_capture_high,
    output logic [7:0] reload_capture_low,
    output logic overflow_flag,
    output logic ext_flag,
    output logic timer_irq
);
    logic [1:0] rst_pipe;
    logic rst_n;
    logic [1:0] pin_raw;
    logic [2:0] sync_q [2];
    logic [1:0] filt;
    logic [1:0] next_filt;
    logic [1:0] fall;
    logic [3:0] presc;
    logic [3:0] next_presc;
    logic tick12;
    trc_pkg::trc_ctrl_t ctrl_q;
    logic [15:0] count;
    logic [15:0] next_count;
    logic [15:0] reload;
    logic [15:0] next_reload;
    logic next_overflow;
    logic next_ext;
    logic clk_pin;
    logic next_clk_pin;
    logic tick;
    logic step;
    logic updown;
    logic clkout_mode;
    logic count_up;
    logic ext_ev;
    logic ovf_ev;
    logic und_ev;

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'h1};
        end
    end
    assign rst_n = rst_pipe[1];

    assign pin_raw = {timer_pin_in, ext_trigger_pin};

    // pin synchronisers: level accepted once second and third stages agree
    genvar g;
    for (g = 0; g < 2; g++) begin : g_sync
        always_comb begin
            next_filt[g] = filt[g];
            if (sync_q[g][1] == sync_q[g][2]) begin
                next_filt[g] = sync_q[g][2];
            end
        end
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                sync_q[g] <= trc_pkg::SYNC_RESET;
                filt[g] <= trc_pkg::LEVEL_RESET;
            end else begin
                sync_q[g] <= {sync_q[g][1:0], pin_raw[g]};
                filt[g] <= next_filt[g];
            end
        end
        // falling edge from consecutive accepted levels
        assign fall[g] = filt[g] & ~next_filt[g];
    end

    always_comb begin
        tick12 = (presc == trc_pkg::PRESCALE_LAST);
        next_presc = tick12 ? trc_pkg::PRESCALE_RESET : 4'(presc + 4'h1);
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            presc <= trc_pkg::PRESCALE_RESET;
        end else begin
            presc <= next_presc;
        end
    end

    // Mode decode from the registered control bits
    always_comb begin
        // down count has no effect in clock-output mode
        updown = ctrl_q.down_count_enable & ~ctrl_q.capture_reload_select
            & ~ctrl_q.clock_out_enable;
        clkout_mode = ctrl_q.clock_out_enable & ~ctrl_q.counter_select;
        // tick source; counter mode takes timer_pin falls; rate
        if (ctrl_q.counter_select) begin
            tick = fall[trc_pkg::PIN_TMR];
        end else begin
            tick = ctrl_q.fast_clock_select | tick12;
        end
        step = ctrl_q.run_enable & tick;
        // direction from the trigger pin level
        count_up = ~updown | filt[trc_pkg::PIN_EXT];
        // edges ignored while ext_enable is clear
        ext_ev = ctrl_q.ext_enable & fall[trc_pkg::PIN_EXT];
    end

    // Counter, reload/capture pair, flags and clock output pin
    always_comb begin
        next_count = count;
        next_reload = reload;
        next_clk_pin = clk_pin;
        ovf_ev = 1'h0;
        und_ev = 1'h0;
        if (step) begin
            if (count_up) begin
                if (count == trc_pkg::COUNT_TOP) begin
                    ovf_ev = 1'h1;
                    // reload on overflow; capture mode wraps to zero
                    next_count = ctrl_q.capture_reload_select ? trc_pkg::COUNT_RESET : reload;
                end else begin
                    next_count = 16'(count + 16'h0001);
                end
            end else if (count == reload) begin
                // down count match loads the top value
                und_ev = 1'h1;
                next_count = trc_pkg::COUNT_TOP;
            end else begin
                next_count = 16'(count - 16'h0001);
            end
        end
        // Software write yields to a capture in the same cycle
        if (reload_write) begin
            next_reload = reload_wdata;
        end
        if (ext_ev && !updown) begin
            if (ctrl_q.capture_reload_select) begin
                // capture the count as it stands
                next_reload = count;
            end else begin
                next_count = reload;
            end
        end
        // Software write of the count overrides hardware this cycle
        if (count_write) begin
            next_count = count_wdata;
        end
        // sticky overflow, set wins over clear
        next_overflow = (overflow_flag & ~overflow_clear) | ovf_ev | und_ev;
        if (updown) begin
            // ext_flag is the seventeenth count bit
            next_ext = (ext_flag & ~ext_clear) ^ (ovf_ev | und_ev);
        end else begin
            // edge sets ext_flag, set wins over clear
            next_ext = (ext_flag & ~ext_clear) | ext_ev;
        end
        // toggle the pin on each overflow in clock-output mode
        if (ovf_ev && clkout_mode) begin
            next_clk_pin = ~clk_pin;
        end
    end

    // everything clears on reset; single 16-bit count
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= trc_pkg::CTRL_RESET;
            count <= trc_pkg::COUNT_RESET;
            reload <= trc_pkg::RELOAD_RESET;
            overflow_flag <= trc_pkg::FLAG_RESET;
            ext_flag <= trc_pkg::FLAG_RESET;
            clk_pin <= trc_pkg::CLK_OUT_RESET;
        end else begin
            ctrl_q <= ctrl;
            count <= next_count;
            reload <= next_reload;
            overflow_flag <= next_overflow;
            ext_flag <= next_ext;
            clk_pin <= next_clk_pin;
        end
    end

    // byte views of the count and the pair
    assign count_high = count[15:8];
    assign count_low = count[7:0];
    assign reload_capture_high = reload[15:8];
    assign reload_capture_low = reload[7:0];
    // Pin is driven only in clock-output mode, so counter input never fights it
    assign timer_pin_oe = clkout_mode;
    assign timer_pin_out = clk_pin;
    // interrupt request; up/down toggles of ext_flag stay silent
    assign timer_irq = ctrl_q.timer_int_enable
        & ((overflow_flag & ~clkout_mode) | (ext_flag & ~updown));

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_top_up;
        step && count_up && count == trc_pkg::COUNT_TOP && !count_write && !ext_ev;
    endsequence
    sequence s_reload_edge;
        ext_ev && !updown && !ctrl_q.capture_reload_select && !count_write;
    endsequence

    property p_halt;
        !ctrl_q.run_enable && !count_write && !ext_ev |=> count == $past(count);
    endproperty
    a_halt: assert property (p_halt) else $error("count moved while halted");

    property p_reload_ovf;
        s_top_up and !ctrl_q.capture_reload_select
            |=> count == $past(reload) && overflow_flag;
    endproperty
    a_reload_ovf: assert property (p_reload_ovf) else $error("no reload on overflow");

    property p_ext_reload;
        s_reload_edge |=> count == $past(reload) && ext_flag;
    endproperty
    a_ext_reload: assert property (p_ext_reload) else $error("edge reload missed");

    property p_capture;
        ext_ev && ctrl_q.capture_reload_select
            |=> reload == $past(count) && ext_flag;
    endproperty
    a_capture: assert property (p_capture) else $error("capture missed");

    property p_underflow;
        step && !count_up && count == reload && !count_write
            |=> count == trc_pkg::COUNT_TOP && overflow_flag;
    endproperty
    a_underflow: assert property (p_underflow) else $error("underflow load wrong");

    property p_bit17;
        updown && (ovf_ev || und_ev) |=> ext_flag != $past(ext_flag);
    endproperty
    a_bit17: assert property (p_bit17) else $error("ext_flag did not toggle");

    property p_clkout;
        clkout_mode && ovf_ev |=> timer_pin_out != $past(timer_pin_out);
    endproperty
    a_clkout: assert property (p_clkout) else $error("clock pin did not toggle");

    property p_prescale;
        tick12 |-> ##12 tick12;
    endproperty
    a_prescale: assert property (p_prescale) else $error("prescale period not 12");

    property p_irq_mask;
        updown && !overflow_flag |-> !timer_irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("ext_flag irq in up/down");

    property p_sync_fall;
        filt[trc_pkg::PIN_EXT] && sync_q[trc_pkg::PIN_EXT][2:1] == 2'h0
            |=> !filt[trc_pkg::PIN_EXT];
    endproperty
    a_sync_fall: assert property (p_sync_fall) else $error("falling level not taken");
endmodule
`default_nettype wire
